// [src/bpp_pkg.sv]
// Shared constants and carrier types for the bidirectional printer port.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
package bpp_pkg;

    // =====================================================================
    // Register map (word indices, one aligned word each)
    // =====================================================================
    localparam logic [3:0] BPP_IDX_DATA = 4'h0;
    localparam logic [3:0] BPP_IDX_STATUS = 4'h1;
    localparam logic [3:0] BPP_IDX_CONTROL = 4'h2;
    localparam logic [3:0] BPP_IDX_IRQ_STAT = 4'h3;
    localparam logic [3:0] BPP_IDX_IRQ_CLR = 4'h4;
    localparam logic [3:0] BPP_IDX_IRQ_EN = 4'h5;
    localparam int BPP_ADDR_W = 6;

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int BPP_CTL_STROBE = 0;
    localparam int BPP_CTL_FEED = 1;
    localparam int BPP_CTL_INIT = 2;
    localparam int BPP_CTL_SELECT = 3;
    localparam int BPP_CTL_IRQ_EN = 4;
    localparam int BPP_CTL_DIR = 5;
    localparam logic [7:0] BPP_CTL_MASK = 8'h3F;
    localparam int BPP_EVT_ACK = 0;
    localparam int BPP_EVT_W = 1;

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [7:0] BPP_DATA_RST = 8'h00;
    localparam logic [7:0] BPP_CTL_RST = 8'h00;
    localparam logic BPP_FLAG_RST = 1'b1;
    localparam logic [1:0] BPP_STAT_RSVD = 2'h3;

    // Printer-side inputs travel together.
    typedef struct packed {
        logic fault_n;
        logic online_in;
        logic no_media_in;
        logic ack_n;
        logic occupied_flag;
    } bpp_prn_in_t;

    typedef enum logic [1:0] {BPP_IDLE, BPP_ACK} bpp_bus_st_t;

endpackage

// [src/bpp_ack_edge.sv]
// Detects the release (low to high) of the active-low acknowledge line.
// Assumes the acknowledge input is already synchronous to clock.
`timescale 1ns/1ps
module bpp_ack_edge
    import bpp_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ack_n,
    output logic release_pulse
);

    logic ack_n_q;

    // =====================================================================
    // Edge detector
    // =====================================================================
    // Idles high so that reset never fakes a release.
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_n_q <= 1'b1;
        end else begin
            ack_n_q <= ack_n;
        end
    end

    assign release_pulse = ack_n & ~ack_n_q;

endmodule

// [src/bpp_top.sv]
// Bidirectional printer port: data, status and control registers on Wishbone.
// Assumes printer inputs are synchronous to clock; pins use split in/out/oe.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps

// Summary of operation
// - Compatibility mode data read returns the last written byte.
// - Compatibility mode data write drives the pins at once.
// - Extended mode read returns written byte, or pins when direction set.
// - Extended mode writes always latch; pins driven only with direction clear.
// - Direction bit only acts with mode pin high.
// - Control bit 5 in extended mode turns data outputs off.
// - Status bits 0 and 1 read as one.
// - Status bit 2 clears when acknowledge is released while control bit 4 is set.
// - Status bit 2 sets again after a status read.
// - Status bits 3-6 follow inputs; bit 7 is inverted occupied input.
// - After reset status bits 0-2 read one.
// - Control reads return the low six bits of the last write; bits 6-7 read zero.
// - Control bits 0,1,3 drive strobe, line feed, select request.
// - Control bit 2 is inverted onto the printer reset output.
// - With bit 4 set, acknowledge release raises the interrupt.
// - With bit 4 clear, the printer interrupt pin floats.
module bpp_top
    import bpp_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [BPP_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic enhanced_mode_pin,
    input wire logic [7:0] parallel_data_pins_i,
    output logic [7:0] parallel_data_pins_o,
    output logic parallel_data_pins_oe_n,
    input wire bpp_prn_in_t prn_in,
    output logic strobe_out,
    output logic line_feed_out,
    output logic printer_init_out,
    output logic select_request_out,
    output logic printer_irq_o,
    output logic printer_irq_oe_n,
    output logic irq
);

    logic [7:0] data_q;
    logic [7:0] ctl_q;
    logic flag_q;
    logic [BPP_EVT_W-1:0] evt_q;
    logic [BPP_EVT_W-1:0] evt_en_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic ack_release;
    logic req;
    logic wr_lane0;
    logic rd_evt;
    logic dir_in;
    logic [7:0] rd_mux;

    // Decode word index from a byte address; used for reads and writes.
    function automatic logic [3:0] word_idx(input logic [BPP_ADDR_W-1:0] a);
        return a[5:2];
    endfunction

    // =====================================================================
    // Bus handshake
    // =====================================================================
    // One wait state: ack comes the cycle after the request and drops after.
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_lane0 = req & wb_we_i & wb_sel_i[0];
    assign rd_evt = req & ~wb_we_i;

    always_ff @(posedge clock) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end
    assign wb_ack_o = ack_q;

    // =====================================================================
    // Data direction
    // =====================================================================
    // Direction is ignored in compatibility mode so the pins stay outputs.
    assign dir_in = enhanced_mode_pin & ctl_q[BPP_CTL_DIR];

    // Output latch is always written, whatever the direction.
    always_ff @(posedge clock) begin
        if (rst) begin
            data_q <= BPP_DATA_RST;
        end else if (wr_lane0 && word_idx(wb_adr_i) == BPP_IDX_DATA) begin
            data_q <= wb_dat_i[7:0];
        end
    end

    assign parallel_data_pins_o = data_q;
    assign parallel_data_pins_oe_n = dir_in;

    // =====================================================================
    // Control register
    // =====================================================================
    // Reserved bits are masked on write so they always read as zero.
    always_ff @(posedge clock) begin
        if (rst) begin
            ctl_q <= BPP_CTL_RST;
        end else if (wr_lane0 && word_idx(wb_adr_i) == BPP_IDX_CONTROL) begin
            ctl_q <= wb_dat_i[7:0] & BPP_CTL_MASK;
        end
    end

    assign strobe_out = ctl_q[BPP_CTL_STROBE];
    assign line_feed_out = ctl_q[BPP_CTL_FEED];
    assign select_request_out = ctl_q[BPP_CTL_SELECT];
    // The output is active high, so a cleared bit asserts the printer reset.
    assign printer_init_out = ~ctl_q[BPP_CTL_INIT];

    // =====================================================================
    // Acknowledge flag
    // =====================================================================
    bpp_ack_edge u_ack_edge (
        .clock(clock),
        .rst(rst),
        .ack_n(prn_in.ack_n),
        .release_pulse(ack_release)
    );

    // A release in the same cycle as a status read wins, so it is not lost.
    always_ff @(posedge clock) begin
        if (rst) begin
            flag_q <= BPP_FLAG_RST;
        end else if (ack_release && ctl_q[BPP_CTL_IRQ_EN]) begin
            flag_q <= 1'b0;
        end else if (rd_evt && word_idx(wb_adr_i) == BPP_IDX_STATUS) begin
            flag_q <= 1'b1;
        end
    end

    // Printer interrupt pin floats unless enabled; it is high while the flag is low.
    assign printer_irq_oe_n = ~ctl_q[BPP_CTL_IRQ_EN];
    assign printer_irq_o = ~flag_q;

    // =====================================================================
    // System interrupt status
    // =====================================================================
    // Sticky event bits; set wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge clock) begin
        if (rst) begin
            evt_q <= '0;
        end else begin
            for (int i = 0; i < BPP_EVT_W; i++) begin
                if (i == BPP_EVT_ACK && ack_release) begin
                    evt_q[i] <= 1'b1;
                end else if (wr_lane0 && word_idx(wb_adr_i) == BPP_IDX_IRQ_CLR
                        && wb_dat_i[i]) begin
                    evt_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            evt_en_q <= '0;
        end else if (wr_lane0 && word_idx(wb_adr_i) == BPP_IDX_IRQ_EN) begin
            evt_en_q <= wb_dat_i[BPP_EVT_W-1:0];
        end
    end

    assign irq = |(evt_q & evt_en_q);

    // =====================================================================
    // Read path
    // =====================================================================
    // Pin data is only visible when the port is turned round to input.
    always_comb begin
        rd_mux = 8'h00;
        case (word_idx(wb_adr_i))
            BPP_IDX_DATA: rd_mux = dir_in ? parallel_data_pins_i : data_q;
            BPP_IDX_STATUS: rd_mux = {~prn_in.occupied_flag, prn_in.ack_n,
                prn_in.no_media_in, prn_in.online_in, prn_in.fault_n,
                flag_q, BPP_STAT_RSVD};
            BPP_IDX_CONTROL: rd_mux = ctl_q;
            BPP_IDX_IRQ_STAT: rd_mux = {{(8-BPP_EVT_W){1'b0}}, evt_q};
            BPP_IDX_IRQ_EN: rd_mux = {{(8-BPP_EVT_W){1'b0}}, evt_en_q};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else if (rd_evt) begin
            rdata_q <= {24'h000000, rd_mux};
        end
    end
    assign wb_dat_o = rdata_q;

    // =====================================================================
    // Checks
    // =====================================================================
    sequence s_status_read;
        rd_evt && word_idx(wb_adr_i) == BPP_IDX_STATUS && !ack_release;
    endsequence

    sequence s_ctl_write;
        wr_lane0 && word_idx(wb_adr_i) == BPP_IDX_CONTROL;
    endsequence

    a_bus_ack_one: assert property (@(posedge clock) disable iff (rst)
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle");
    a_compat_drive: assert property (@(posedge clock) disable iff (rst)
        !enhanced_mode_pin |-> !parallel_data_pins_oe_n)
        else $error("pins not driven in compatibility mode");
    a_dir_float: assert property (@(posedge clock) disable iff (rst)
        enhanced_mode_pin && ctl_q[BPP_CTL_DIR] |-> parallel_data_pins_oe_n)
        else $error("pins driven with direction set");
    a_data_write: assert property (@(posedge clock) disable iff (rst)
        wr_lane0 && word_idx(wb_adr_i) == BPP_IDX_DATA
        |=> parallel_data_pins_o == $past(wb_dat_i[7:0]))
        else $error("data write not latched");
    a_flag_clear: assert property (@(posedge clock) disable iff (rst)
        $rose(prn_in.ack_n) && ctl_q[BPP_CTL_IRQ_EN] |=> !flag_q)
        else $error("flag not cleared on ack release");
    a_flag_reset: assert property (@(posedge clock) disable iff (rst)
        s_status_read |=> flag_q)
        else $error("flag not set after status read");
    a_status_rsvd: assert property (@(posedge clock) disable iff (rst)
        s_status_read |=> wb_dat_o[1:0] == 2'h3 && wb_dat_o[7] == !$past(prn_in.occupied_flag))
        else $error("status read value wrong");
    a_init_invert: assert property (@(posedge clock) disable iff (rst)
        s_ctl_write |=> printer_init_out == !$past(wb_dat_i[BPP_CTL_INIT]))
        else $error("printer reset output not inverted");
    a_irq_float: assert property (@(posedge clock) disable iff (rst)
        !ctl_q[BPP_CTL_IRQ_EN] |-> printer_irq_oe_n)
        else $error("printer irq driven while disabled");
    a_ctl_rsvd: assert property (@(posedge clock) disable iff (rst)
        ctl_q[7:6] == 2'h0)
        else $error("control reserved bits set");

    // =====================================================================
    // Checks: data path
    // =====================================================================
    // Each step of a data access is named once so the properties stay short.
    sequence s_compat_write;
        wr_lane0 && word_idx(wb_adr_i) == BPP_IDX_DATA && !enhanced_mode_pin;
    endsequence

    sequence s_latch_read;
        rd_evt && word_idx(wb_adr_i) == BPP_IDX_DATA && !dir_in;
    endsequence

    sequence s_pin_read;
        rd_evt && word_idx(wb_adr_i) == BPP_IDX_DATA && enhanced_mode_pin && ctl_q[BPP_CTL_DIR];
    endsequence

    // A compatibility write must reach the pins on the very next cycle.
    a_compat_pins: assert property (@(posedge clock) disable iff (rst)
        s_compat_write |=> parallel_data_pins_o == $past(wb_dat_i[7:0])
            && (enhanced_mode_pin || !parallel_data_pins_oe_n))
        else $error("compatibility write not on the pins");
    // Reads with the port driving return the latch, never the pins.
    a_latch_read: assert property (@(posedge clock) disable iff (rst)
        s_latch_read |=> wb_dat_o[7:0] == $past(data_q))
        else $error("data read did not return the latch");
    a_pin_read: assert property (@(posedge clock) disable iff (rst)
        s_pin_read |=> wb_dat_o[7:0] == $past(parallel_data_pins_i))
        else $error("data read did not return the pins");
    a_ext_drive: assert property (@(posedge clock) disable iff (rst)
        enhanced_mode_pin && !ctl_q[BPP_CTL_DIR] |-> !parallel_data_pins_oe_n)
        else $error("pins not driven with direction clear");

    // =====================================================================
    // Checks: control register
    // =====================================================================
    sequence s_ctl_read;
        rd_evt && word_idx(wb_adr_i) == BPP_IDX_CONTROL;
    endsequence

    // Low six bits are kept as written; the top two are dropped.
    a_ctl_write: assert property (@(posedge clock) disable iff (rst)
        s_ctl_write |=> ctl_q[5:0] == $past(wb_dat_i[5:0]))
        else $error("control write not kept");
    a_ctl_read: assert property (@(posedge clock) disable iff (rst)
        s_ctl_read |=> wb_dat_o[7:0] == $past(ctl_q))
        else $error("control read value wrong");
    a_ctl_lines: assert property (@(posedge clock) disable iff (rst)
        s_ctl_write |=> strobe_out == $past(wb_dat_i[BPP_CTL_STROBE])
            && line_feed_out == $past(wb_dat_i[BPP_CTL_FEED])
            && select_request_out == $past(wb_dat_i[BPP_CTL_SELECT]))
        else $error("control lines do not follow the write");

    // =====================================================================
    // Checks: interrupts
    // =====================================================================
    sequence s_live_release;
        ack_release && ctl_q[BPP_CTL_IRQ_EN];
    endsequence

    sequence s_quiet_release;
        ack_release && !ctl_q[BPP_CTL_IRQ_EN]
            && !(rd_evt && word_idx(wb_adr_i) == BPP_IDX_STATUS);
    endsequence

    sequence s_evt_clear;
        wr_lane0 && word_idx(wb_adr_i) == BPP_IDX_IRQ_CLR && wb_dat_i[BPP_EVT_ACK]
            && !ack_release;
    endsequence

    // An enabled release must show on the printer pin one cycle later.
    a_irq_raise: assert property (@(posedge clock) disable iff (rst)
        s_live_release |=> printer_irq_o && !printer_irq_oe_n)
        else $error("enabled release raised no interrupt");
    // With the pin disabled the flag must not move on a release.
    a_flag_keep: assert property (@(posedge clock) disable iff (rst)
        s_quiet_release |=> flag_q == $past(flag_q))
        else $error("flag moved while interrupts disabled");
    a_irq_drop: assert property (@(posedge clock) disable iff (rst)
        s_status_read |=> !printer_irq_o)
        else $error("printer irq still high after status read");
    a_evt_set: assert property (@(posedge clock) disable iff (rst)
        ack_release |=> evt_q[BPP_EVT_ACK])
        else $error("release event not recorded");
    a_evt_clear: assert property (@(posedge clock) disable iff (rst)
        s_evt_clear |=> !evt_q[BPP_EVT_ACK])
        else $error("release event not cleared");
    a_sys_irq: assert property (@(posedge clock) disable iff (rst)
        evt_q[BPP_EVT_ACK] && evt_en_q[BPP_EVT_ACK] |-> irq)
        else $error("system interrupt not raised");

    // =====================================================================
    // Checks: reset and status
    // =====================================================================
    // No disable here: the edge right after release is the one to watch.
    a_reset_idle: assert property (@(posedge clock)
        $fell(rst) |-> flag_q && ctl_q == BPP_CTL_RST && !wb_ack_o)
        else $error("state not idle after reset");
    a_status_lines: assert property (@(posedge clock) disable iff (rst)
        s_status_read |=> wb_dat_o[6] == $past(prn_in.ack_n)
            && wb_dat_o[3] == $past(prn_in.fault_n) && wb_dat_o[2] == $past(flag_q))
        else $error("status input bits wrong");

endmodule

// [tb/bpp_printer_model.sv]
// Behavioural printer that sits on the far side of the printer port.
// Assumes the bench drives its controls by non-blocking assignment at a rising edge.
`timescale 1ns/1ps
module bpp_printer_model
    import bpp_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ack_req,
    input wire logic [3:0] lines,
    input wire logic [7:0] own_byte,
    input wire logic [7:0] dev_byte,
    input wire logic dev_oe_n,
    input wire logic clash,
    output bpp_prn_in_t prn_in,
    output logic [7:0] pins
);
    // =====================================================================
    // Acknowledge handshake
    // =====================================================================
    logic [2:0] ack_cnt_q;

    // A request starts a three-cycle low pulse on acknowledge, then it is released.
    always_ff @(posedge clock) begin
        if (rst || ack_req) begin
            ack_cnt_q <= rst ? 3'h0 : 3'h3;
        end else if (ack_cnt_q != 3'h0) begin
            ack_cnt_q <= ack_cnt_q - 3'h1;
        end
    end

    // Status lines come from the bench; acknowledge is low while the pulse runs.
    assign prn_in = '{lines[3], lines[2], lines[1], (ack_cnt_q == 3'h0), lines[0]};

    // The printer drives its own byte whenever the port lets the data wire go,
    // or when the bench forces a clash so that latch and pins can be told apart.
    assign pins = (dev_oe_n | clash) ? own_byte : dev_byte;
endmodule

// [tb/test_bidir_printer_port.sv]
// Self-checking bench for the printer port over classic Wishbone.
// Assumes bpp_top and the printer model; one 20 MHz clock.
`timescale 1ns/1ps
module test_bidir_printer_port;
    import bpp_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0] sel = 4'hF;
    logic mode = 1'b0;
    logic ack_req = 1'b0;
    logic clash = 1'b0;
    logic [3:0] lines = 4'hC;
    logic [7:0] rd;
    logic [31:0] wb_dat_o;
    logic [7:0] pins_i, pins_o;
    logic wb_ack_o, oe_n, stb_o, feed_o, init_o, sel_o, pirq, pirq_oe_n, irq;
    bpp_prn_in_t prn;
    int err_total = 0;
    int comparisons = 0;

    always #25 clock = ~clock;

    bpp_top u_dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .enhanced_mode_pin(mode), .parallel_data_pins_i(pins_i),
        .parallel_data_pins_o(pins_o), .parallel_data_pins_oe_n(oe_n), .prn_in(prn),
        .strobe_out(stb_o), .line_feed_out(feed_o), .printer_init_out(init_o),
        .select_request_out(sel_o), .printer_irq_o(pirq), .printer_irq_oe_n(pirq_oe_n),
        .irq(irq));

    bpp_printer_model u_prn (.clock(clock), .rst(rst), .ack_req(ack_req), .lines(lines),
        .own_byte(8'h5A), .dev_byte(pins_o), .dev_oe_n(oe_n), .clash(clash), .prn_in(prn),
        .pins(pins_i));

    // =====================================================================
    // Bus and check tasks
    // =====================================================================
    task automatic give_verdict;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask

    // One classic cycle; the request is held until ack is seen at an edge.
    // No local limit: only the watchdog may end a wait for ack.
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h000000, d};
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask

    // Acknowledge pulse, then time for the release to be seen.
    task automatic pulse;
        ack_req <= 1'b1;
        @(posedge clock);
        ack_req <= 1'b0;
        repeat (8) @(posedge clock);
    endtask

    // Expected status byte with acknowledge released.
    function automatic logic [7:0] st(input logic flag);
        return {~lines[0], 1'b1, lines[1], lines[2], lines[3], flag, 2'b11};
    endfunction

    // =====================================================================
    // Scenarios
    // =====================================================================
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk({7'h00, init_o}, 8'h01);
        chk({7'h00, pirq_oe_n}, 8'h01);
        rdchk(6'h04, st(1'b1));
        rdchk(6'h08, 8'h00);
        lines <= 4'h3;
        @(posedge clock);
        rdchk(6'h04, st(1'b1));
        xfer(1'b1, 6'h08, 8'hFF);
        rdchk(6'h08, 8'h3F);
        chk({4'h0, stb_o, feed_o, init_o, sel_o}, 8'h0D);
        chk({7'h00, oe_n}, 8'h00);
        xfer(1'b1, 6'h08, 8'h00);
        chk({4'h0, stb_o, feed_o, init_o, sel_o}, 8'h02);
        // A write with lane 0 off must leave the control register alone.
        sel <= 4'hE;
        xfer(1'b1, 6'h08, 8'hFF);
        sel <= 4'hF;
        rdchk(6'h08, 8'h00);
        // Compatibility mode keeps driving even with direction set.
        xfer(1'b1, 6'h00, 8'hA5);
        chk(pins_o, 8'hA5);
        xfer(1'b1, 6'h08, 8'h20);
        chk({7'h00, oe_n}, 8'h00);
        // The printer fights the pins here, so only the latch can give A5.
        clash <= 1'b1;
        rdchk(6'h00, 8'hA5);
        clash <= 1'b0;
        // Extended mode with direction set reads the printer's byte.
        mode <= 1'b1;
        repeat (2) @(posedge clock);
        chk({7'h00, oe_n}, 8'h01);
        rdchk(6'h00, 8'h5A);
        xfer(1'b1, 6'h00, 8'h77);
        rdchk(6'h00, 8'h5A);
        xfer(1'b1, 6'h08, 8'h00);
        repeat (2) @(posedge clock);
        chk({oe_n, pins_o[6:0]}, 8'h77);
        clash <= 1'b1;
        rdchk(6'h00, 8'h77);
        clash <= 1'b0;
        // Enabled acknowledge release: flag, pin and interrupt.
        xfer(1'b1, 6'h14, 8'h01);
        xfer(1'b1, 6'h08, 8'h10);
        chk({7'h00, pirq_oe_n}, 8'h00);
        pulse();
        chk({6'h00, pirq, irq}, 8'h03);
        rdchk(6'h0C, 8'h01);
        rdchk(6'h04, st(1'b0));
        rdchk(6'h04, st(1'b1));
        chk({7'h00, pirq}, 8'h00);
        xfer(1'b1, 6'h10, 8'h01);
        chk({7'h00, irq}, 8'h00);
        rdchk(6'h0C, 8'h00);
        // Masked and disabled: the event is kept but nothing is raised.
        xfer(1'b1, 6'h14, 8'h00);
        xfer(1'b1, 6'h08, 8'h00);
        // Read status while the printer still holds acknowledge low.
        ack_req <= 1'b1;
        @(posedge clock);
        ack_req <= 1'b0;
        rdchk(6'h04, st(1'b1) & 8'hBF);
        repeat (8) @(posedge clock);
        rdchk(6'h0C, 8'h01);
        chk({6'h00, pirq_oe_n, irq}, 8'h02);
        rdchk(6'h04, st(1'b1));
        rdchk(6'h3C, 8'h00);
        // A second reset mid-run returns control and event state to idle.
        xfer(1'b1, 6'h08, 8'h1F);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk({7'h00, pirq_oe_n}, 8'h01);
        rdchk(6'h08, 8'h00);
        rdchk(6'h0C, 8'h00);
        rdchk(6'h04, st(1'b1));
        give_verdict();
    end

    // Cut a hang short well beyond the expected hundred and forty or so cycles.
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        give_verdict();
    end
endmodule
